// [bhp_pkg.sv]
/*
 holds constants of the host-protocol front end: state bits, events, command ids, frame layout.
 assumes nothing of its surroundings.
*/
package bhp_pkg;
    // ------------------------------------------------------------
    // state bitmap
    // ------------------------------------------------------------
    localparam logic [15:0] ST_READY    = 16'h0001;
    localparam logic [15:0] ST_CAPTURE  = 16'h0004;
    localparam logic [15:0] ST_IMAGE    = 16'h0010;
    localparam logic [15:0] ST_XFER     = 16'h0040;
    localparam logic [15:0] ST_FINGER   = 16'h0080;
    localparam logic [15:0] ST_SYSERR   = 16'h0400;
    localparam logic [15:0] ST_ENROLL   = 16'h1000;
    localparam logic [15:0] ST_IDENT    = 16'h2000;
    localparam logic [15:0] ST_NAV      = 16'h4000;
    localparam logic [15:0] ST_ABORTABLE = 16'h7054;
    localparam logic [15:0] ST_SEARCH   = 16'h7004;
    localparam logic [15:0] ST_RESET    = 16'h0000;
    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    localparam logic [15:0] EV_NONE     = 16'h0000;
    localparam logic [15:0] EV_IDLE     = 16'h0001;
    localparam logic [15:0] EV_FDETECT  = 16'h0003;
    localparam logic [15:0] EV_FLOST    = 16'h0004;
    localparam logic [15:0] EV_IMAGE    = 16'h0005;
    localparam logic [15:0] EV_FAILED   = 16'h0006;
    // ------------------------------------------------------------
    // commands and frame layout
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_STATUS   = 16'h0040;
    localparam logic [15:0] CMD_CAPTURE  = 16'h0050;
    localparam logic [15:0] CMD_ABORT    = 16'h0052;
    localparam logic [15:0] CMD_IMGDATA  = 16'h0053;
    localparam logic [15:0] CMD_ENROLL   = 16'h0054;
    localparam logic [15:0] CMD_IDENT    = 16'h0055;
    localparam logic [15:0] CMD_NAV      = 16'h0200;
    localparam logic [15:0] PROTO_VER    = 16'h0004;
    localparam logic [15:0] MSG_TYPE_RSP = 16'h0012;
    localparam logic [15:0] RSP_PAYLOAD  = 16'h0004;
    localparam logic [3:0]  FRAME_HDR_LEN = 4'h8;
    localparam logic [3:0]  CMD_HDR_LEN   = 4'h4;
    localparam logic [4:0]  RSP_LEN       = 5'h10;
endpackage

// [bhp_skid.sv]
/*
 holds a two-entry byte buffer with valid/ready on both sides.
 assumes one clock and a synchronous copy of reset.
*/
`timescale 1ns/100ps
module bhp_skid #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data
);
    initial begin
        if (WIDTH < 1) $error("width must be positive");
    end

    logic [WIDTH-1:0] mem_reg [2];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    assign o_ready = (count_reg != 2'h2);
    assign o_valid = (count_reg != 2'h0);
    assign o_data  = mem_reg[rd_ptr_reg];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop) count_reg <= count_reg + 2'h1;
            else if (pop && !push) count_reg <= count_reg - 2'h1;
        end
    end
endmodule

// [bhp_core.sv]
/*
 holds the protocol front end: frame parser, state bitmap, status response builder.
 assumes a byte stream from a transport on i_clk and sensor/engine event strobes on i_clk.
*/
`timescale 1ns/100ps
// How it works
// - sixteen-bit state bitmap, bits combine freely
// - one search mode at once, else error
// - ready bit survives abort
// - capture arms; capture yields image; abort clears
// - image bit clears after image readout
// - transfer bit held during session, abort clears
// - finger bit only while searching; abort keeps
// - error bit clears once code read
// - enroll bit clears at completion or abort
// - identify bit clears at result or abort
// - navigation bit held until abort
// - every command answered with state, event
// - idle event at startup; none is zero
// - touch while searching raises detect; leave raises lost
// - image ready event; failed command event
// - frame header, command header, then payload
// - multi-byte fields least significant first
// - version, type, flags, length, two bytes each
// - wrong version frame silently dropped
// - command id then type, payload after
// - abort and status command identifiers
module bhp_core (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // receive byte stream
    input  wire logic       i_rx_valid,
    output logic            o_rx_ready,
    input  wire logic [7:0] i_rx_data,
    // transmit byte stream
    output logic            o_tx_valid,
    input  wire logic       i_tx_ready,
    output logic [7:0]      o_tx_data,
    // engine events, one-cycle pulses
    input  wire logic       i_app_ready,
    input  wire logic       i_touch,
    input  wire logic       i_lift,
    input  wire logic       i_image_taken,
    input  wire logic       i_image_read,
    input  wire logic       i_xfer_start,
    input  wire logic       i_xfer_end,
    input  wire logic       i_sys_error,
    input  wire logic       i_error_read,
    input  wire logic       i_enroll_done,
    input  wire logic       i_match_reported,
    // status
    output logic [15:0]     o_state,
    output logic [15:0]     o_cmd_id,
    output logic            o_cmd_strobe
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_b;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) rst_sync_reg <= 2'b00;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_b = rst_sync_reg[1];

    // ------------------------------------------------------------
    // receive parser
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RX_HDR, RX_SKIP, RX_WAIT} bhp_rx_t;
    bhp_rx_t     rx_state_reg;
    logic [3:0]  rx_idx_reg;
    logic [7:0]  rx_lo_reg;
    logic [15:0] rx_ver_reg;
    logic [15:0] rx_len_reg;
    logic [15:0] rx_cmd_reg;
    logic [15:0] skip_reg;
    logic        rx_take;
    logic        hdr_done;
    logic        cmd_go;
    logic        resp_busy;
    logic [15:0] word_in;

    assign o_rx_ready = (rx_state_reg != RX_WAIT);
    assign rx_take    = i_rx_valid && o_rx_ready;
    assign word_in    = {i_rx_data, rx_lo_reg};
    assign hdr_done   = rx_take && (rx_state_reg == RX_HDR)
                        && (rx_idx_reg == bhp_pkg::FRAME_HDR_LEN + bhp_pkg::CMD_HDR_LEN - 4'h1);

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state_reg <= RX_HDR;
            rx_idx_reg   <= 4'h0;
            rx_lo_reg    <= 8'h00;
            rx_ver_reg   <= 16'h0000;
            rx_len_reg   <= 16'h0000;
            rx_cmd_reg   <= 16'h0000;
            skip_reg     <= 16'h0000;
        end else begin
            case (rx_state_reg)
                RX_HDR: begin
                    if (rx_take) begin
                        rx_lo_reg  <= i_rx_data;
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        case (rx_idx_reg)
                            4'h1: rx_ver_reg <= word_in;
                            4'h7: rx_len_reg <= word_in;
                            4'h9: rx_cmd_reg <= word_in;
                            default: ;
                        endcase
                        if (hdr_done) begin
                            rx_idx_reg <= 4'h0;
                            skip_reg   <= rx_len_reg;
                            if (rx_len_reg != 16'h0000) rx_state_reg <= RX_SKIP;
                            else if (rx_ver_reg == bhp_pkg::PROTO_VER) rx_state_reg <= RX_WAIT;
                        end
                    end
                end
                RX_SKIP: begin
                    // payloads are not interpreted here, only consumed
                    if (rx_take) begin
                        skip_reg <= skip_reg - 16'h0001;
                        if (skip_reg == 16'h0001) begin
                            if (rx_ver_reg == bhp_pkg::PROTO_VER) rx_state_reg <= RX_WAIT;
                            else rx_state_reg <= RX_HDR;
                        end
                    end
                end
                RX_WAIT: begin
                    if (cmd_go) rx_state_reg <= RX_HDR;
                end
                default: rx_state_reg <= RX_HDR;
            endcase
        end
    end

    // one command at a time: a parsed frame waits until the previous response is all in the skid buffer
    assign cmd_go = (rx_state_reg == RX_WAIT) && !resp_busy;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    function automatic logic [15:0] mode_bit(input logic [15:0] cmd);
        case (cmd)
            bhp_pkg::CMD_CAPTURE: mode_bit = bhp_pkg::ST_CAPTURE;
            bhp_pkg::CMD_ENROLL:  mode_bit = bhp_pkg::ST_ENROLL;
            bhp_pkg::CMD_IDENT:   mode_bit = bhp_pkg::ST_IDENT;
            bhp_pkg::CMD_NAV:     mode_bit = bhp_pkg::ST_NAV;
            default:              mode_bit = 16'h0000;
        endcase
    endfunction

    logic [15:0] state_reg;
    logic [15:0] want;
    logic        is_abort;
    logic        refuse;
    logic        searching;

    assign want      = mode_bit(rx_cmd_reg);
    assign is_abort  = (rx_cmd_reg == bhp_pkg::CMD_ABORT);
    assign searching = |(state_reg & bhp_pkg::ST_SEARCH);
    assign refuse    = (want != 16'h0000) && searching;

    // ------------------------------------------------------------
    // state bitmap
    // ------------------------------------------------------------
    logic [15:0] state_next;
    always_comb begin
        state_next = state_reg;
        if (i_app_ready) state_next = state_next | bhp_pkg::ST_READY;
        if (i_image_read) state_next = state_next & ~bhp_pkg::ST_IMAGE;
        if (i_xfer_end) state_next = state_next & ~bhp_pkg::ST_XFER;
        if (i_error_read) state_next = state_next & ~bhp_pkg::ST_SYSERR;
        if (i_enroll_done) state_next = state_next & ~bhp_pkg::ST_ENROLL;
        if (i_match_reported) state_next = state_next & ~bhp_pkg::ST_IDENT;
        if (i_lift) state_next = state_next & ~bhp_pkg::ST_FINGER;
        if (cmd_go && is_abort) state_next = state_next & ~bhp_pkg::ST_ABORTABLE;
        if (cmd_go && !refuse) state_next = state_next | want;
        if (i_image_taken && state_reg[2]) begin
            state_next = (state_next & ~bhp_pkg::ST_CAPTURE) | bhp_pkg::ST_IMAGE;
        end
        if (i_xfer_start) state_next = state_next | bhp_pkg::ST_XFER;
        if (i_sys_error) state_next = state_next | bhp_pkg::ST_SYSERR;
        if (i_touch && searching) state_next = state_next | bhp_pkg::ST_FINGER;
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) state_reg <= bhp_pkg::ST_RESET;
        else state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // pending event, reported with the next response
    // ------------------------------------------------------------
    logic [15:0] event_reg;
    logic        resp_go;
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            event_reg <= bhp_pkg::EV_IDLE;
        end else if (cmd_go && refuse) begin
            event_reg <= bhp_pkg::EV_FAILED;
        end else if (i_touch && searching) begin
            event_reg <= bhp_pkg::EV_FDETECT;
        end else if (i_lift) begin
            event_reg <= bhp_pkg::EV_FLOST;
        end else if (i_image_taken) begin
            event_reg <= bhp_pkg::EV_IMAGE;
        end else if (resp_go) begin
            event_reg <= bhp_pkg::EV_NONE;
        end
    end

    // ------------------------------------------------------------
    // response builder
    // ------------------------------------------------------------
    logic [3:0]  tx_idx_reg;
    logic        resp_reg;
    logic        go_d_reg;
    logic [15:0] snap_state_reg;
    logic [15:0] snap_event_reg;
    logic        tx_push;
    logic        tx_ready;
    logic [7:0]  tx_byte;

    assign resp_busy = resp_reg || go_d_reg;
    assign resp_go   = go_d_reg;

    // waiting a cycle lets the snapshot show the bitmap after the command
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) go_d_reg <= 1'b0;
        else go_d_reg <= cmd_go;
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            resp_reg       <= 1'b0;
            tx_idx_reg     <= 4'h0;
            snap_state_reg <= 16'h0000;
            snap_event_reg <= 16'h0000;
        end else if (go_d_reg) begin
            resp_reg       <= 1'b1;
            tx_idx_reg     <= 4'h0;
            snap_state_reg <= state_reg;
            snap_event_reg <= event_reg;
        end else if (tx_push) begin
            tx_idx_reg <= tx_idx_reg + 4'h1;
            if ({1'b0, tx_idx_reg} == bhp_pkg::RSP_LEN - 5'h1) resp_reg <= 1'b0;
        end
    end

    function automatic logic [7:0] pick(input logic [15:0] w, input logic hi);
        pick = hi ? w[15:8] : w[7:0];
    endfunction

    always_comb begin
        case (tx_idx_reg[3:1])
            3'h0: tx_byte = pick(bhp_pkg::PROTO_VER, tx_idx_reg[0]);
            3'h1: tx_byte = pick(bhp_pkg::MSG_TYPE_RSP, tx_idx_reg[0]);
            3'h2: tx_byte = 8'h00;
            3'h3: tx_byte = pick(bhp_pkg::RSP_PAYLOAD, tx_idx_reg[0]);
            3'h4: tx_byte = pick(bhp_pkg::CMD_STATUS, tx_idx_reg[0]);
            3'h5: tx_byte = 8'h00;
            3'h6: tx_byte = pick(snap_state_reg, tx_idx_reg[0]);
            3'h7: tx_byte = pick(snap_event_reg, tx_idx_reg[0]);
            default: tx_byte = 8'h00;
        endcase
    end

    assign tx_push = resp_reg && tx_ready;

    bhp_skid #(
        .WIDTH(8)
    ) u_skid (
        .i_clk   (i_clk),
        .i_rst_b (rst_b),
        .i_valid (resp_reg),
        .o_ready (tx_ready),
        .i_data  (tx_byte),
        .o_valid (o_tx_valid),
        .i_ready (i_tx_ready),
        .o_data  (o_tx_data)
    );

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_cmd_id     <= 16'h0000;
            o_cmd_strobe <= 1'b0;
        end else begin
            o_cmd_strobe <= cmd_go;
            if (cmd_go) o_cmd_id <= rx_cmd_reg;
        end
    end

    assign o_state = state_reg;
endmodule

// [bhp_core_props.sv]
/*
 assertions on the ports of bhp_core.
 assumes one clock and the active-low reset of the top ports.
*/
`timescale 1ns/100ps
module bhp_core_props (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    // engine events and sink
    input wire logic        i_tx_ready,
    input wire logic        i_touch,
    input wire logic        i_lift,
    input wire logic        i_image_taken,
    input wire logic        i_image_read,
    input wire logic        i_xfer_start,
    input wire logic        i_sys_error,
    input wire logic        i_error_read,
    input wire logic        i_enroll_done,
    input wire logic        i_match_reported,
    // outputs
    input wire logic        o_tx_valid,
    input wire logic [7:0]  o_tx_data,
    input wire logic [15:0] o_state
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence stalled_s;
        o_tx_valid && !i_tx_ready;
    endsequence
    sequence kept_s;
        o_tx_valid && $stable(o_tx_data);
    endsequence
    a_ready_sticky: assert property (!$fell(o_state[0]))
        else $error("ready bit dropped");
    a_one_mode: assert property ($onehot0(o_state & bhp_pkg::ST_SEARCH))
        else $error("two search modes active");
    a_finger_search: assert property ($rose(o_state[7]) |-> $past(|(o_state & bhp_pkg::ST_SEARCH)))
        else $error("finger bit set while not searching");
    a_image_arm: assert property ($rose(o_state[4]) |-> $fell(o_state[2]))
        else $error("image bit without arm handover");
    a_touch_detect: assert property (i_touch && !i_lift && |(o_state & bhp_pkg::ST_SEARCH) |=> o_state[7])
        else $error("touch did not set finger bit");
    a_lift_lost: assert property (i_lift && !i_touch |=> !o_state[7])
        else $error("lift did not clear finger bit");
    a_image_read: assert property (i_image_read && !i_image_taken |=> !o_state[4])
        else $error("image bit kept after readout");
    a_xfer_held: assert property (i_xfer_start |=> o_state[6])
        else $error("transfer bit not set");
    a_err_set: assert property (i_sys_error |=> o_state[10])
        else $error("error bit not set");
    a_err_clear: assert property (i_error_read && !i_sys_error |=> !o_state[10])
        else $error("error bit kept after read");
    a_enroll_end: assert property (i_enroll_done |=> !o_state[12])
        else $error("enroll bit kept after completion");
    a_match_end: assert property (i_match_reported |=> !o_state[13])
        else $error("identify bit kept after result");
    a_tx_hold: assert property (stalled_s |=> kept_s)
        else $error("response byte lost under stall");
endmodule

bind bhp_core bhp_core_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_tx_ready(i_tx_ready),
    .i_touch(i_touch), .i_lift(i_lift), .i_image_taken(i_image_taken), .i_image_read(i_image_read),
    .i_xfer_start(i_xfer_start), .i_sys_error(i_sys_error), .i_error_read(i_error_read),
    .i_enroll_done(i_enroll_done), .i_match_reported(i_match_reported), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_state(o_state));

// [bhp_host.sv]
/*
 host model: frames commands onto the rx stream, collects response bytes.
 assumes the block's clock; changes its outputs at the falling edge.
*/
`timescale 1ns/100ps
module bhp_host (
    // clock
    input  wire logic       i_clk,
    // command stream
    input  wire logic       i_rx_ready,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    // response stream
    input  wire logic       i_tx_valid,
    output logic            o_tx_ready,
    input  wire logic [7:0] i_tx_data
);
    // host message type, value of our choosing
    localparam logic [15:0] CMD_MSG_TYPE = 16'h0011;
    logic       stall = 1'b0;
    logic [1:0] ph = 2'h0;
    logic [7:0] rsp [$];
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_tx_ready = 1'b0;
    end
    // stalled sink takes one byte in four; the byte is recorded at the falling
    // edge, where valid and data already stand for the coming rising edge
    always @(negedge i_clk) begin : sink
        logic rdy;
        rdy = !stall || ph == 2'h0;
        ph <= ph + 2'h1;
        o_tx_ready <= rdy;
        if (i_tx_valid && rdy) begin
            rsp.push_back(i_tx_data);
        end
    end
    task automatic put(input logic [7:0] b);
        @(negedge i_clk);
        o_rx_valid = 1'b1;
        o_rx_data = b;
        // ready only moves at rising edges, so judge it settled mid-cycle
        for (int i = 0; i < 400 && !i_rx_ready; i++) @(negedge i_clk);
        @(posedge i_clk);
    endtask
    task automatic send_frame(input logic [15:0] ver, input logic [15:0] id, input logic [15:0] len);
        logic [15:0] f [6];
        f = '{ver, CMD_MSG_TYPE, 16'h0000, len, id, 16'h0000};
        foreach (f[k]) begin
            put(f[k][7:0]);
            put(f[k][15:8]);
        end
        for (int k = 0; k < len; k++) begin
            put(8'h5a ^ k[7:0]);
        end
        // released line shows no stale byte
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        o_rx_data = ~o_rx_data;
    endtask
endmodule

// [tb.sv]
/*
 self-checking bench of bhp_core: mode table, events, abort, refusals, stall, reset.
 assumes bhp_host drives both byte streams.
*/
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [15:0] PV = bhp_pkg::PROTO_VER;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        rx_valid;
    logic        rx_ready;
    logic [7:0]  rx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [7:0]  tx_data;
    // ready, touch, lift, taken, read, xstart, xend, syserr, errread, enrdone, match
    logic [10:0] ev_in = 11'h000;
    logic [15:0] o_state;
    logic [15:0] o_cmd_id;
    int          error_cnt = 0;
    int          comparisons = 0;
    // id, state, event
    logic [15:0] rows [12][3] = '{
        '{16'h0040, 16'h0001, 16'h0001}, '{16'h0050, 16'h0005, 16'h0000}, '{16'h0054, 16'h0005, 16'h0006},
        '{16'h0052, 16'h0001, 16'h0000}, '{16'h0054, 16'h1001, 16'h0000}, '{16'h0052, 16'h0001, 16'h0000},
        '{16'h0055, 16'h2001, 16'h0000}, '{16'h0200, 16'h2001, 16'h0006}, '{16'h0052, 16'h0001, 16'h0000},
        '{16'h0200, 16'h4001, 16'h0000}, '{16'h0050, 16'h4001, 16'h0006}, '{16'h0052, 16'h0001, 16'h0000}};
    always #2 i_clk = ~i_clk;
    bhp_core uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
        .i_rx_data(rx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_data(tx_data),
        .i_app_ready(ev_in[0]), .i_touch(ev_in[1]), .i_lift(ev_in[2]), .i_image_taken(ev_in[3]),
        .i_image_read(ev_in[4]), .i_xfer_start(ev_in[5]), .i_xfer_end(ev_in[6]), .i_sys_error(ev_in[7]),
        .i_error_read(ev_in[8]), .i_enroll_done(ev_in[9]), .i_match_reported(ev_in[10]),
        .o_state(o_state), .o_cmd_id(o_cmd_id), .o_cmd_strobe());
    bhp_host host (.i_clk(i_clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int k, input logic [15:0] st);
        @(negedge i_clk);
        ev_in[k] = 1'b1;
        @(negedge i_clk);
        ev_in[k] = 1'b0;
        chk(o_state, st);
    endtask
    task automatic chk_rsp(input logic [15:0] st, input logic [15:0] ev);
        logic [15:0] e [8];
        logic [7:0]  lo;
        e = '{PV, bhp_pkg::MSG_TYPE_RSP, 16'h0000, bhp_pkg::RSP_PAYLOAD, bhp_pkg::CMD_STATUS, 16'h0000, st, ev};
        for (int i = 0; i < 2000 && host.rsp.size() < 16; i++) @(negedge i_clk);
        for (int k = 0; k < 8; k++) begin
            lo = host.rsp.pop_front();
            chk({host.rsp.pop_front(), lo}, e[k]);
        end
    endtask
    task automatic do_cmd(input logic [15:0] ver, id, len, st, ev);
        host.send_frame(ver, id, len);
        if (ver !== PV) begin
            repeat (80) @(negedge i_clk);
            chk(16'(host.rsp.size()), 16'h0000);
        end else begin
            chk_rsp(st, ev);
            chk(o_cmd_id, id);
        end
        @(negedge i_clk);
        chk(o_state, st);
    endtask
    task automatic cmd(input logic [15:0] id, st, ev);
        do_cmd(PV, id, 16'h0000, st, ev);
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (3) @(negedge i_clk);
        pulse(0, 16'h0001);
        for (int r = 0; r < 12; r++) begin
            host.stall = r[0];
            cmd(rows[r][0], rows[r][1], rows[r][2]);
        end
        cmd(16'h0050, 16'h0005, 16'h0000);
        pulse(1, 16'h0085);
        cmd(16'h0040, 16'h0085, 16'h0003);
        pulse(3, 16'h0091);
        cmd(16'h0040, 16'h0091, 16'h0005);
        pulse(2, 16'h0011);
        cmd(16'h0040, 16'h0011, 16'h0004);
        pulse(4, 16'h0001);
        pulse(1, 16'h0001);
        cmd(16'h0054, 16'h1001, 16'h0000);
        pulse(1, 16'h1081);
        cmd(16'h0052, 16'h0081, 16'h0003);
        pulse(2, 16'h0001);
        cmd(16'h0040, 16'h0001, 16'h0004);
        cmd(16'h0054, 16'h1001, 16'h0000);
        pulse(9, 16'h0001);
        cmd(16'h0055, 16'h2001, 16'h0000);
        pulse(10, 16'h0001);
        pulse(5, 16'h0041);
        pulse(6, 16'h0001);
        pulse(5, 16'h0041);
        pulse(7, 16'h0441);
        cmd(16'h0052, 16'h0401, 16'h0000);
        pulse(8, 16'h0001);
        do_cmd(16'h0005, 16'h0050, 16'h0000, 16'h0001, 16'h0000);
        // back to back frames, the first with payload, sink stalling
        host.stall = 1'b1;
        host.send_frame(PV, 16'h0040, 16'h0002);
        do_cmd(PV, 16'h0040, 16'h0000, 16'h0001, 16'h0000);
        chk_rsp(16'h0001, 16'h0000);
        host.stall = 1'b0;
        i_rst_b = 1'b0;
        repeat (2) @(negedge i_clk);
        chk(o_state, 16'h0000);
        chk({15'h0000, tx_valid}, 16'h0000);
        i_rst_b = 1'b1;
        repeat (3) @(negedge i_clk);
        pulse(0, 16'h0001);
        cmd(16'h0040, 16'h0001, 16'h0001);
        complete_run();
    end
    // watchdog, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge i_clk);
        error_cnt++;
        complete_run();
    end
endmodule
